/* common/swc_pkg.sv */
package swc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_WDT = 8'h0c;

    // Control register fields.
    localparam int CTRL_W = 8;
    localparam int CB_GLOB_INT = 0;
    localparam int CB_WDT_EN = 1;
    localparam int CB_WDT_SLEEP = 2;
    localparam int CB_MASTER_CLR_EN = 3;
    localparam int CB_BROWNOUT_EN = 4;
    localparam int CB_ADC_EN = 5;
    localparam int CB_ADC_RC = 6;
    localparam int CB_T1OSC_EN = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h1a;

    // Status register fields.
    localparam int SB_POWER_DOWN = 0;
    localparam int SB_TIMEOUT = 1;
    localparam int SB_ASLEEP = 2;
    localparam int SB_WAKE_INT = 3;
    localparam int SB_WAKE_WDT = 4;
    localparam int SB_FULL_RST = 5;
    localparam int SB_CPS_ON = 6;

    localparam int LF_OSC_KHZ = 31;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } swc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } swc_axi_rsp_t;

    typedef enum logic [1:0] {
        SWC_RUN,
        SWC_SLEEP,
        SWC_WAKE
    } swc_state_t;
endpackage

/* hw/swc_sleep_ctrl.sv */
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Sleep is entered only when the core executes the sleep instruction.
// - Sleep entry clears watchdog; it keeps counting in sleep if enabled.
// - Sleep entry clears power_down_flag.
// - Sleep entry sets timeout_flag.
// - Core clock is gated off while asleep.
// - The 31 kHz low_freq_internal_osc keeps running in sleep.
// - The secondary timer oscillator keeps running in sleep.
// - Converter runs in sleep on its own RC clock; capacitive sensing runs.
// - All I/O pins hold their pre-sleep drive state during sleep.
// - Non-watchdog resets behave the same asleep as awake.
// - Wake on master clear, brownout, power-on, watchdog or interrupts.
// - Master clear, brownout, power-on do full reset; others continue.
// - Executing sleep prefetches the instruction at PC plus one.
// - Interrupt wakes only if its enable is set, regardless of global enable.
// - Without global enable continue; with it, run next then vector.
// - Watchdog is cleared on every wake from sleep.
// - Pending enabled interrupt, global enable clear: sleep acts as no-op.
// - Interrupt during or after sleep: full entry then immediate wake.
module swc_sleep_ctrl #(
    parameter int NUM_INT = 4,
    parameter int PC_W = 13,
    parameter int NUM_PINS = 8,
    parameter int WDT_W = 16,
    parameter int PRE_W = 5,
    parameter logic [WDT_W-1:0] WDT_LIMIT = 16'h0400
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire swc_pkg::swc_axi_req_t axi_i,
    output swc_pkg::swc_axi_rsp_t axi_o,
    input wire logic sleep_exec_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic [NUM_INT-1:0] int_flag_i,
    input wire logic lf_tick_i,
    input wire logic master_clear_i,
    input wire logic brownout_i,
    input wire logic por_i,
    input wire logic cps_en_i,
    input wire logic [NUM_PINS-1:0] pin_out_i,
    input wire logic [NUM_PINS-1:0] pin_oe_i,
    output logic cpu_clk_en_r,
    output logic [PC_W-1:0] prefetch_addr_r,
    output logic resume_r,
    output logic vector_after_next_r,
    output logic device_reset_r,
    output logic wdt_reset_r,
    output logic lfosc_run_r,
    output logic t1osc_run_r,
    output logic adc_run_r,
    output logic cps_run_r,
    output logic [NUM_PINS-1:0] pin_out_r,
    output logic [NUM_PINS-1:0] pin_oe_r
);
    swc_pkg::swc_state_t state_r;
    logic [swc_pkg::CTRL_W-1:0] ctrl_r;
    logic [NUM_INT-1:0] int_en_r;
    logic power_down_flag_r;
    logic timeout_flag_r;
    logic wake_int_r;
    logic wake_wdt_r;
    logic full_rst_r;
    logic [WDT_W-1:0] wdt_cnt_r;
    logic [PRE_W-1:0] wdt_pre_r;

    logic glob_int_en;
    logic pending;
    logic rst_evt;
    logic asleep;
    logic waking;
    logic wdt_run;
    logic wdt_expire;
    logic sleep_nop;
    logic sleep_go;

    // Bus state.
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [swc_pkg::DATA_W-1:0] rdata_r;
    logic [1:0] rresp_r;
    logic aw_have_r;
    logic w_have_r;
    logic [swc_pkg::ADDR_W-1:0] waddr_r;
    logic [swc_pkg::DATA_W-1:0] wdata_r;
    logic [swc_pkg::STRB_W-1:0] wstrb_r;
    logic wr_fire;
    logic [swc_pkg::DATA_W-1:0] rd_word;
    logic rd_ok;
    logic wr_ok;

    assign axi_o.awready = awready_r;
    assign axi_o.wready = wready_r;
    assign axi_o.bvalid = bvalid_r;
    assign axi_o.bresp = bresp_r;
    assign axi_o.arready = arready_r;
    assign axi_o.rvalid = rvalid_r;
    assign axi_o.rdata = rdata_r;
    assign axi_o.rresp = rresp_r;

    assign glob_int_en = ctrl_r[swc_pkg::CB_GLOB_INT];
    assign pending = |(int_flag_i & int_en_r);
    assign rst_evt = por_i
        | (master_clear_i & ctrl_r[swc_pkg::CB_MASTER_CLR_EN])
        | (brownout_i & ctrl_r[swc_pkg::CB_BROWNOUT_EN]);
    assign asleep = (state_r == swc_pkg::SWC_SLEEP);
    assign waking = (state_r == swc_pkg::SWC_WAKE);
    // The sleep request is honoured only from the run state.
    assign sleep_nop = (state_r == swc_pkg::SWC_RUN) && sleep_exec_i
        && pending && !glob_int_en;
    assign sleep_go = (state_r == swc_pkg::SWC_RUN) && sleep_exec_i
        && !sleep_nop && !rst_evt;
    assign wdt_run = ctrl_r[swc_pkg::CB_WDT_EN]
        && (!asleep || ctrl_r[swc_pkg::CB_WDT_SLEEP]);
    assign wdt_expire = wdt_run && (wdt_cnt_r == WDT_LIMIT);

    // Sequencer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= swc_pkg::SWC_RUN;
        end else if (rst_evt) begin
            state_r <= swc_pkg::SWC_RUN;
        end else begin
            case (state_r)
                swc_pkg::SWC_RUN: begin
                    if (sleep_go) begin
                        state_r <= swc_pkg::SWC_SLEEP;
                    end
                end
                swc_pkg::SWC_SLEEP: begin
                    // A flag raised during the sleep cycle wakes at once.
                    if (pending || wdt_expire) begin
                        state_r <= swc_pkg::SWC_WAKE;
                    end
                end
                swc_pkg::SWC_WAKE: begin
                    state_r <= swc_pkg::SWC_RUN;
                end
                default: begin
                    state_r <= swc_pkg::SWC_RUN;
                end
            endcase
        end
    end

    // Core clock gate; the sleep-exit condition re-opens it one cycle before resume.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_en_r <= 1'b1;
        end else if (rst_evt) begin
            cpu_clk_en_r <= 1'b1;
        end else if (sleep_go) begin
            cpu_clk_en_r <= 1'b0;
        end else if (asleep && (pending || wdt_expire)) begin
            cpu_clk_en_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resume_r <= 1'b0;
            vector_after_next_r <= 1'b0;
        end else begin
            resume_r <= waking && !rst_evt;
            if (waking && !rst_evt) begin
                vector_after_next_r <= glob_int_en && wake_int_r;
            end else if (sleep_go) begin
                vector_after_next_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prefetch_addr_r <= '0;
        end else if (sleep_exec_i && (state_r == swc_pkg::SWC_RUN)) begin
            prefetch_addr_r <= pc_i + PC_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            device_reset_r <= 1'b0;
            wdt_reset_r <= 1'b0;
        end else begin
            device_reset_r <= rst_evt;
            // An expiry while awake is a reset; while asleep it is a wake.
            wdt_reset_r <= wdt_expire && !asleep && !rst_evt;
        end
    end

    // Watchdog with its prescaler.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_cnt_r <= '0;
            wdt_pre_r <= '0;
        end else if (rst_evt || sleep_go || wdt_expire) begin
            wdt_cnt_r <= '0;
            wdt_pre_r <= '0;
        end else if (asleep && pending) begin
            wdt_cnt_r <= '0;
            wdt_pre_r <= '0;
        end else if (wdt_run && lf_tick_i) begin
            wdt_pre_r <= wdt_pre_r + PRE_W'(1);
            if (&wdt_pre_r) begin
                wdt_cnt_r <= wdt_cnt_r + WDT_W'(1);
            end
        end
    end

    // Status flags; a no-op sleep leaves them untouched.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down_flag_r <= 1'b1;
            timeout_flag_r <= 1'b1;
        end else if (por_i) begin
            power_down_flag_r <= 1'b1;
            timeout_flag_r <= 1'b1;
        end else if (sleep_go) begin
            power_down_flag_r <= 1'b0;
            timeout_flag_r <= 1'b1;
        end else if (wdt_expire && !rst_evt) begin
            timeout_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_int_r <= 1'b0;
            wake_wdt_r <= 1'b0;
            full_rst_r <= 1'b0;
        end else if (rst_evt) begin
            wake_int_r <= 1'b0;
            wake_wdt_r <= 1'b0;
            full_rst_r <= 1'b1;
        end else if (sleep_go) begin
            wake_int_r <= 1'b0;
            wake_wdt_r <= 1'b0;
            full_rst_r <= 1'b0;
        end else if (asleep && pending) begin
            wake_int_r <= 1'b1;
        end else if (asleep && wdt_expire) begin
            wake_wdt_r <= 1'b1;
        end
    end

    // Clock sources that must survive sleep.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfosc_run_r <= 1'b1;
            t1osc_run_r <= 1'b0;
            adc_run_r <= 1'b0;
            cps_run_r <= 1'b0;
        end else begin
            lfosc_run_r <= 1'b1;
            t1osc_run_r <= ctrl_r[swc_pkg::CB_T1OSC_EN];
            adc_run_r <= ctrl_r[swc_pkg::CB_ADC_EN]
                && (!asleep || ctrl_r[swc_pkg::CB_ADC_RC]);
            cps_run_r <= cps_en_i;
        end
    end

    // Pins follow the port while awake and freeze for the whole sleep.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
        end else if (!asleep) begin
            pin_out_r <= pin_out_i;
            pin_oe_r <= pin_oe_i;
        end
    end

    // Write channel: address and data taken in either order.
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wr_ok = (waddr_r == swc_pkg::OFF_CTRL)
        || (waddr_r == swc_pkg::OFF_INT_EN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= swc_pkg::RESP_OKAY;
        end else begin
            if (axi_i.awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_have_r <= 1'b1;
                waddr_r <= {axi_i.awaddr[swc_pkg::ADDR_W-1:2], 2'h0};
            end
            if (axi_i.wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_have_r <= 1'b1;
                wdata_r <= axi_i.wdata;
                wstrb_r <= axi_i.wstrb;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
            end
            if (bvalid_r && axi_i.bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= swc_pkg::CTRL_RST;
            int_en_r <= '0;
        end else if (wr_fire && wstrb_r[0]) begin
            if (waddr_r == swc_pkg::OFF_CTRL) begin
                ctrl_r <= wdata_r[swc_pkg::CTRL_W-1:0];
            end
            if (waddr_r == swc_pkg::OFF_INT_EN) begin
                int_en_r <= wdata_r[NUM_INT-1:0];
            end
        end
    end

    // Read channel.
    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        case ({axi_i.araddr[swc_pkg::ADDR_W-1:2], 2'h0})
            swc_pkg::OFF_CTRL: begin
                rd_word[swc_pkg::CTRL_W-1:0] = ctrl_r;
            end
            swc_pkg::OFF_INT_EN: begin
                rd_word[NUM_INT-1:0] = int_en_r;
            end
            swc_pkg::OFF_STATUS: begin
                rd_word[swc_pkg::SB_POWER_DOWN] = power_down_flag_r;
                rd_word[swc_pkg::SB_TIMEOUT] = timeout_flag_r;
                rd_word[swc_pkg::SB_ASLEEP] = asleep;
                rd_word[swc_pkg::SB_WAKE_INT] = wake_int_r;
                rd_word[swc_pkg::SB_WAKE_WDT] = wake_wdt_r;
                rd_word[swc_pkg::SB_FULL_RST] = full_rst_r;
                rd_word[swc_pkg::SB_CPS_ON] = cps_run_r;
            end
            swc_pkg::OFF_WDT: begin
                rd_word[WDT_W-1:0] = wdt_cnt_r;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= swc_pkg::RESP_OKAY;
        end else if (axi_i.arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_ok ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
        end else if (rvalid_r && axi_i.rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    clk_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep |-> !cpu_clk_en_r)
        else $error("core clock running while asleep");

    entry_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_go |=> asleep && !power_down_flag_r && timeout_flag_r
            && wdt_cnt_r == '0)
        else $error("sleep entry flags or watchdog wrong");

    nop_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_nop && !rst_evt && !wdt_expire |=> !asleep
            && $stable(power_down_flag_r)
            && $stable(timeout_flag_r))
        else $error("no-op sleep changed state");

    int_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep && pending && !rst_evt |=> waking
            ##1 (resume_r || $past(rst_evt)))
        else $error("enabled interrupt did not wake");

    clk_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
        resume_r |-> cpu_clk_en_r && $past(cpu_clk_en_r))
        else $error("resume before core clock enabled");

    wake_wdt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        waking |-> wdt_cnt_r == '0 && wdt_pre_r == '0)
        else $error("watchdog not cleared on wake");

    pins_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep && $past(asleep) |-> $stable(pin_out_r)
            && $stable(pin_oe_r))
        else $error("pin state moved during sleep");

    por_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep && por_i |=> device_reset_r && !asleep
            && !resume_r)
        else $error("power-on in sleep did not reset");

    prefetch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_go |=> prefetch_addr_r == $past(pc_i) + PC_W'(1))
        else $error("wrong prefetch address");

    lf_osc_a: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep |-> lfosc_run_r ##1 lfosc_run_r)
        else $error("low frequency oscillator stopped");
endmodule

/* bench/swc_core_model.sv */
`timescale 1ns/1ps
// Core stand-in: issues the sleep instruction on request and counts the
// instructions that advance, which they do only while its clock is enabled.
module swc_core_model #(
    parameter int PC_W = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic [PC_W-1:0] go_pc,
    input wire logic cpu_clk_en_r,
    output logic sleep_exec_i,
    output logic [PC_W-1:0] pc_i,
    output logic [15:0] instr_cnt
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_exec_i <= 1'b0;
            pc_i <= '0;
        end else begin
            // A stopped core cannot execute anything, sleep included.
            sleep_exec_i <= go && cpu_clk_en_r;
            // The address means nothing without the strobe, so it toggles.
            pc_i <= go ? go_pc : ~pc_i;
        end
    end

    // The slot after sleep holds a no_operation, so counting is all it does.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_cnt <= '0;
        end else if (cpu_clk_en_r) begin
            instr_cnt <= instr_cnt + 16'h1;
        end
    end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int PC_W = 13;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    swc_pkg::swc_axi_req_t req = '0;
    swc_pkg::swc_axi_rsp_t rsp;
    logic go = 1'b0;
    logic [PC_W-1:0] go_pc = '0;
    logic [PC_W-1:0] pc, pf;
    logic sleep_exec, clk_en, resume, vec, dev_rst, wdt_rst;
    logic lfosc, t1osc, adc, cps;
    logic [3:0] int_flag = '0;
    logic lf_tick = 1'b0;
    logic tick_on = 1'b0;
    logic [2:0] rst_src = '0;
    logic cps_en = 1'b0;
    logic [7:0] pin_o = '0;
    logic [7:0] pin_e = '0;
    logic [7:0] pin_or, pin_er;
    logic [15:0] icnt;
    int err_count = 0;
    int checks = 0;
    int resumes = 0;
    int wdt_hits = 0;
    logic tick_awake = 1'b0;

    always #5 aclk = ~aclk;

    swc_sleep_ctrl #(.WDT_LIMIT(16'h0004), .PRE_W(1)) dut (
        .aclk(aclk), .aresetn(aresetn), .axi_i(req), .axi_o(rsp),
        .sleep_exec_i(sleep_exec), .pc_i(pc), .int_flag_i(int_flag),
        .lf_tick_i(lf_tick), .master_clear_i(rst_src[0]),
        .brownout_i(rst_src[1]),
        .por_i(rst_src[2]), .cps_en_i(cps_en), .pin_out_i(pin_o),
        .pin_oe_i(pin_e), .cpu_clk_en_r(clk_en), .prefetch_addr_r(pf),
        .resume_r(resume), .vector_after_next_r(vec),
        .device_reset_r(dev_rst), .wdt_reset_r(wdt_rst),
        .lfosc_run_r(lfosc), .t1osc_run_r(t1osc), .adc_run_r(adc),
        .cps_run_r(cps), .pin_out_r(pin_or), .pin_oe_r(pin_er)
    );

    swc_core_model #(.PC_W(PC_W)) core (
        .aclk(aclk), .aresetn(aresetn), .go(go), .go_pc(go_pc),
        .cpu_clk_en_r(clk_en), .sleep_exec_i(sleep_exec), .pc_i(pc),
        .instr_cnt(icnt)
    );

    always @(posedge aclk) begin
        // Unless tick_awake is set, ticks stop once the core clock returns,
        // so the count after a watchdog wake stays at zero until it is read.
        lf_tick <= tick_on && (tick_awake || !clk_en)
            && ($urandom % 3 == 0);
        if (wdt_rst === 1'b1) wdt_hits <= wdt_hits + 1;
        pin_o <= 8'($urandom);
        pin_e <= 8'($urandom);
        if (resume === 1'b1) resumes <= resumes + 1;
    end

    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    // The low-frequency oscillator always runs; the converter only on its RC.
    function automatic logic [31:0] osc_exp(input logic [7:0] c,
                                            input logic e);
        return {28'h0, 1'b1, c[swc_pkg::CB_T1OSC_EN],
            c[swc_pkg::CB_ADC_EN] & c[swc_pkg::CB_ADC_RC], e};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 50);
        req.bready <= 1'b0;
        chk(32'(rsp.bvalid), 32'h1, "no write response");
        chk(32'(rsp.bresp), 32'(er), "write response");
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] mask,
                      input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 50);
        req.rready <= 1'b0;
        chk(32'(rsp.rvalid), 32'h1, "no read response");
        chk(rsp.rdata & mask, ed, "read data");
        chk(32'(rsp.rresp), 32'(er), "read response");
        @(posedge aclk);
    endtask

    // Sleep lands two edges after the request, so three edges let it settle.
    task automatic do_sleep(input logic [PC_W-1:0] p);
        go <= 1'b1;
        go_pc <= p;
        @(posedge aclk);
        go <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        int i;
        int r0;
        logic [7:0] cfg;
        logic [15:0] c;
        logic [7:0] frz;
        logic [PC_W-1:0] p;
        void'($urandom(32'h74ec4d21));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(swc_pkg::OFF_CTRL, 32'hff, 32'h1a, swc_pkg::RESP_OKAY);
        rd(swc_pkg::OFF_INT_EN, 32'hf, 32'h0, swc_pkg::RESP_OKAY);
        rd(swc_pkg::OFF_STATUS, 32'h7, 32'h3, swc_pkg::RESP_OKAY);
        rd(8'h10, 32'hffffffff, 32'h0, swc_pkg::RESP_SLVERR);
        wr(swc_pkg::OFF_STATUS, 32'h0, swc_pkg::RESP_SLVERR);
        wr(swc_pkg::OFF_CTRL, 32'h18, swc_pkg::RESP_OKAY);
        wr(swc_pkg::OFF_INT_EN, 32'h1, swc_pkg::RESP_OKAY);
        int_flag <= 4'h1;
        do_sleep(PC_W'($urandom));
        chk(32'(clk_en), 32'h1, "sleep not skipped");
        rd(swc_pkg::OFF_STATUS, 32'h7, 32'h3, swc_pkg::RESP_OKAY);
        int_flag <= 4'h0;
        for (i = 0; i < 6; i++) begin
            cfg = {3'($urandom), 4'b1100, 1'(i)};
            wr(swc_pkg::OFF_CTRL, 32'(cfg), swc_pkg::RESP_OKAY);
            cps_en <= 1'($urandom);
            p = (i == 0) ? '1 : PC_W'($urandom);
            do_sleep(p);
            chk(32'(clk_en), 32'h0, "core clock on");
            chk(32'(pf), 32'(PC_W'(p + 1'b1)), "prefetch");
            c = icnt;
            frz = pin_or;
            int_flag <= 4'h2;
            repeat (5) @(posedge aclk);
            chk(32'(icnt), 32'(c), "core advanced");
            chk(32'(pin_or), 32'(frz), "pins moved");
            chk(32'({lfosc, t1osc, adc, cps}),
                osc_exp(cfg, cps_en), "osc run");
            rd(swc_pkg::OFF_STATUS, 32'h7, 32'h6, swc_pkg::RESP_OKAY);
            r0 = resumes;
            int_flag <= 4'h1;
            repeat (6) @(posedge aclk);
            chk(32'(resumes - r0), 32'h1, "no wake");
            chk(32'(clk_en), 32'h1, "clock off");
            chk(32'(vec), 32'(cfg[0]), "vector");
            int_flag <= 4'h0;
        end
        wr(swc_pkg::OFF_CTRL, 32'h19, swc_pkg::RESP_OKAY);
        int_flag <= 4'h1;
        r0 = resumes;
        do_sleep(PC_W'($urandom));
        repeat (4) @(posedge aclk);
        chk(32'(resumes - r0), 32'h1, "pending wake");
        rd(swc_pkg::OFF_STATUS, 32'h3, 32'h2, swc_pkg::RESP_OKAY);
        int_flag <= 4'h0;
        wr(swc_pkg::OFF_CTRL, 32'h1e, swc_pkg::RESP_OKAY);
        do_sleep(PC_W'($urandom));
        r0 = resumes;
        tick_on <= 1'b1;
        for (i = 0; i < 400 && resumes == r0; i++) @(posedge aclk);
        tick_on <= 1'b0;
        chk(32'(resumes - r0), 32'h1, "watchdog wake");
        chk(32'({vec, dev_rst}), 32'h0, "watchdog kind");
        rd(swc_pkg::OFF_STATUS, 32'h12, 32'h10, swc_pkg::RESP_OKAY);
        rd(swc_pkg::OFF_WDT, 32'hffff, 32'h0, swc_pkg::RESP_OKAY);
        wr(swc_pkg::OFF_CTRL, 32'h10, swc_pkg::RESP_OKAY);
        do_sleep(PC_W'($urandom));
        rst_src <= 3'h1;
        repeat (4) @(posedge aclk);
        chk(32'(clk_en), 32'h0, "disabled reset woke");
        rst_src <= 3'h0;
        for (i = 0; i < 3; i++) begin
            wr(swc_pkg::OFF_CTRL, 32'h18, swc_pkg::RESP_OKAY);
            do_sleep(PC_W'($urandom));
            r0 = resumes;
            rst_src <= 3'(1 << i);
            repeat (3) @(posedge aclk);
            chk(32'({dev_rst, clk_en}), 32'h3, "reset wake");
            rst_src <= 3'h0;
            repeat (3) @(posedge aclk);
            chk(32'(resumes - r0), 32'h0, "resumed");
            rd(swc_pkg::OFF_STATUS, 32'h3, (i == 2) ? 32'h3 : 32'h2,
               swc_pkg::RESP_OKAY);
        end
        wr(swc_pkg::OFF_CTRL, 32'h1a, swc_pkg::RESP_OKAY);
        r0 = wdt_hits;
        tick_awake <= 1'b1;
        tick_on <= 1'b1;
        for (i = 0; i < 400 && wdt_hits == r0; i++) @(posedge aclk);
        tick_on <= 1'b0;
        chk(32'(wdt_hits - r0), 32'h1, "awake expiry");
        chk(32'({clk_en, resume}), 32'h2, "awake expiry kind");
        rd(swc_pkg::OFF_STATUS, 32'h2, 32'h0, swc_pkg::RESP_OKAY);
        tally_and_finish();
    end

    initial begin
        #200000;
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
